// ===== rtl/board_reset_pkg.sv
// constants and types for the board reset and interrupt glue
package board_reset_pkg;

  // board clock
  localparam int unsigned CLK_PERIOD_NS   = 4;

  // least time power-on reset stays active after release
  localparam int unsigned POR_MIN_NS      = 150_000_000;
  // least time a push-button level must stay put before it is accepted
  localparam int unsigned DEBOUNCE_MIN_NS = 10_000_000;

  // least times round up to whole cycles
  localparam int unsigned POR_CYCLES      = (POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter widths, wide enough for the default counts
  localparam int unsigned POR_CNT_W       = 28;
  localparam int unsigned DEB_CNT_W       = 24;

  // pin synchroniser lanes
  localparam int unsigned SYNC_W          = 11;
  localparam int unsigned LANE_PWR_GOOD   = 0;
  localparam int unsigned LANE_BUTTON     = 1;
  localparam int unsigned LANE_DBG_HRST   = 2;
  localparam int unsigned LANE_DBG_SRST   = 3;
  localparam int unsigned LANE_CPU_HRST   = 4;
  localparam int unsigned LANE_PHY_IRQ    = 5;
  localparam int unsigned LANE_RTC_IRQ    = 6;
  localparam int unsigned LANE_PCI_INTA   = 7;
  localparam int unsigned LANE_PCI_INTB   = 8;
  localparam int unsigned LANE_USB_ILIM   = 9;
  localparam int unsigned LANE_USB_THERM  = 10;

  // idle value of the synchroniser: active-low lanes high, others low
  // lanes 1 to 8 are active low; supply good and the usb faults idle low
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 11'h1fe;

  // values of the registered outputs during and right after reset
  localparam logic RST_LEVEL_ON   = 1'b0;  // active-low reset lines asserted
  localparam logic RST_LEVEL_OFF  = 1'b1;
  localparam logic IRQ_LEVEL_IDLE = 1'b1;  // active-low interrupt lines idle
  localparam logic BUTTON_IDLE    = 1'b0;  // debounced press flag, released

  // power-on reset sequencer
  typedef enum logic [1:0] {
    POR_HOLD  = 2'b00,
    POR_COUNT = 2'b01,
    POR_DONE  = 2'b10
  } por_state_t;

endpackage

// ===== rtl/board_reset_glue.sv
// board reset sequencing and external interrupt routing for the host card
//
// Behaviour
// - one common reset line drives the host processor and every board peripheral
// - power-on, hard and soft reset each leave on their own output
// - hard reset active while debug reset request or processor hard-reset output is
// - power-on reset held at least 150 ms after button release and good 3.3 V
// - debug controller pulls its reset line low; passed straight to hard reset
// - push button is debounced into manual_reset_input, one clean reset per press
// - soft reset follows only the debug port soft-reset request
// - soft reset makes processor abort transactions and reload register defaults
// - phy and real-time-clock interrupts ORed onto ext_irq_line_b
// - slot INTA goes to ext_irq_line_d, INTB to ext_irq_line_e
// - current limit, thermal shutdown or undervoltage lockout raise usb fault on line c
`timescale 1ns/100ps
`default_nettype none

module board_reset_glue
  import board_reset_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES = POR_CYCLES,
  parameter int unsigned DEBOUNCE_LEN    = DEBOUNCE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  // reset sources, all asynchronous pins
  input  wire logic pwr_good_3v3,
  input  wire logic push_button_n,
  input  wire logic dbg_hard_reset_req_n,
  input  wire logic dbg_soft_reset_req_n,
  input  wire logic cpu_hard_reset_out_n,
  // interrupt sources, all asynchronous pins
  input  wire logic phy_link_irq_n,
  input  wire logic timekeeper_irq_n,
  input  wire logic pci_inta_n,
  input  wire logic pci_intb_n,
  input  wire logic usb_current_limit,
  input  wire logic usb_thermal_shutdown,
  input  wire logic undervoltage_lockout,
  // reset outputs
  output logic      power_on_reset_out_n,
  output logic      hard_reset_n,
  output logic      soft_reset_line_n,
  output logic      board_reset_n,
  output logic      manual_reset_input,
  // interrupt outputs toward the processor, active low except usb_power_fault_irq, which is active high
  output logic      ext_irq_line_b_n,
  output logic      ext_irq_line_c_n,
  output logic      ext_irq_line_d_n,
  output logic      ext_irq_line_e_n,
  output logic      usb_power_fault_irq
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;

  // gather pins into lanes; undervoltage lockout has its own lane below
  assign pin_raw[LANE_PWR_GOOD]  = pwr_good_3v3;
  assign pin_raw[LANE_BUTTON]    = push_button_n;
  assign pin_raw[LANE_DBG_HRST]  = dbg_hard_reset_req_n;
  assign pin_raw[LANE_DBG_SRST]  = dbg_soft_reset_req_n;
  assign pin_raw[LANE_CPU_HRST]  = cpu_hard_reset_out_n;
  assign pin_raw[LANE_PHY_IRQ]   = phy_link_irq_n;
  assign pin_raw[LANE_RTC_IRQ]   = timekeeper_irq_n;
  assign pin_raw[LANE_PCI_INTA]  = pci_inta_n;
  assign pin_raw[LANE_PCI_INTB]  = pci_intb_n;
  assign pin_raw[LANE_USB_ILIM]  = usb_current_limit;
  assign pin_raw[LANE_USB_THERM] = usb_thermal_shutdown;

  // two flops per lane; only sync_ff is read by logic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= SYNC_IDLE;
      sync_ff <= SYNC_IDLE;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
    end
  end

  logic undervoltage_lockout_meta_ff;
  logic undervoltage_lockout_sync_ff;

  // separate lane so the package idle vector stays narrow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      undervoltage_lockout_meta_ff <= 1'b0;
      undervoltage_lockout_sync_ff <= 1'b0;
    end else begin
      undervoltage_lockout_meta_ff <= undervoltage_lockout;
      undervoltage_lockout_sync_ff <= undervoltage_lockout_meta_ff;
    end
  end

  // named views of the synchronised lanes
  wire pwr_good       = sync_ff[LANE_PWR_GOOD];
  wire button_pressed = ~sync_ff[LANE_BUTTON];
  wire dbg_hrst_req   = ~sync_ff[LANE_DBG_HRST];
  wire dbg_srst_req   = ~sync_ff[LANE_DBG_SRST];
  wire cpu_hrst_req   = ~sync_ff[LANE_CPU_HRST];

  // ------------------------------------------------------------------
  // push-button debounce
  // ------------------------------------------------------------------
  logic                 button_ff;
  logic [DEB_CNT_W-1:0] deb_cnt_ff;
  logic                 nxt_button;
  logic [DEB_CNT_W-1:0] nxt_deb_cnt;

  // the counter only runs while the pin disagrees with the accepted level,
  // so contact bounce keeps restarting it and never reaches the end
  wire deb_differs = button_pressed != button_ff;
  wire deb_expired = deb_cnt_ff == DEB_CNT_W'(DEBOUNCE_LEN - 1);

  assign nxt_button  = (deb_differs && deb_expired) ? button_pressed : button_ff;
  assign nxt_deb_cnt = (!deb_differs || deb_expired) ? '0
                                                     : deb_cnt_ff + DEB_CNT_W'(1);

  // accepted button level and stability counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      button_ff  <= BUTTON_IDLE;
      deb_cnt_ff <= '0;
    end else begin
      button_ff  <= nxt_button;
      deb_cnt_ff <= nxt_deb_cnt;
    end
  end

  // ------------------------------------------------------------------
  // power-on reset sequencer
  // ------------------------------------------------------------------
  por_state_t           por_state_ff;
  por_state_t           nxt_por_state;
  logic [POR_CNT_W-1:0] por_cnt_ff;
  logic [POR_CNT_W-1:0] nxt_por_cnt;

  // any loss of supply or a new press restarts the full hold time
  wire por_cause   = button_ff || !pwr_good;
  wire por_expired = por_cnt_ff == POR_CNT_W'(POR_HOLD_CYCLES - 1);

  // state transitions
  always_comb begin
    nxt_por_state = por_state_ff;
    unique case (por_state_ff)
      POR_HOLD: begin
        if (!por_cause) begin
          nxt_por_state = POR_COUNT;
        end
      end
      POR_COUNT: begin
        if (por_cause) begin
          nxt_por_state = POR_HOLD;
        end else if (por_expired) begin
          nxt_por_state = POR_DONE;
        end
      end
      POR_DONE: begin
        if (por_cause) begin
          nxt_por_state = POR_HOLD;
        end
      end
      default: begin
        nxt_por_state = POR_HOLD;
      end
    endcase
  end

  // hold counter only advances while counting toward release
  assign nxt_por_cnt = (por_state_ff == POR_COUNT && !por_cause && !por_expired)
                       ? por_cnt_ff + POR_CNT_W'(1)
                       : '0;

  // sequencer state and hold counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_state_ff <= POR_HOLD;
      por_cnt_ff   <= '0;
    end else begin
      por_state_ff <= nxt_por_state;
      por_cnt_ff   <= nxt_por_cnt;
    end
  end

  // ------------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------------
  logic nxt_por_n;
  logic nxt_hard_n;
  logic nxt_soft_n;
  logic nxt_board_n;

  // power-on reset only drops once the sequencer reaches done
  assign nxt_por_n   = (nxt_por_state == POR_DONE) ? RST_LEVEL_OFF : RST_LEVEL_ON;
  // debug request passes through untouched, no filtering or stretching
  assign nxt_hard_n  = (dbg_hrst_req || cpu_hrst_req) ? RST_LEVEL_ON
                                                      : RST_LEVEL_OFF;
  // soft reset listens to the debug port alone
  assign nxt_soft_n  = dbg_srst_req ? RST_LEVEL_ON : RST_LEVEL_OFF;
  // one shared line for processor and peripherals
  assign nxt_board_n = nxt_por_n & nxt_hard_n;

  // every reset output leaves from a flop, so release lines up with the clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      power_on_reset_out_n <= RST_LEVEL_ON;
      hard_reset_n         <= RST_LEVEL_OFF;
      soft_reset_line_n    <= RST_LEVEL_OFF;
      board_reset_n        <= RST_LEVEL_ON;
      manual_reset_input   <= BUTTON_IDLE;
    end else begin
      power_on_reset_out_n <= nxt_por_n;
      hard_reset_n         <= nxt_hard_n;
      soft_reset_line_n    <= nxt_soft_n;
      board_reset_n        <= nxt_board_n;
      manual_reset_input   <= button_ff;
    end
  end

  // ------------------------------------------------------------------
  // interrupt routing
  // ------------------------------------------------------------------
  logic nxt_irq_b_n;
  logic nxt_irq_c_n;
  logic nxt_irq_d_n;
  logic nxt_irq_e_n;
  logic nxt_usb_fault;

  // active-low OR of two active-low sources is an AND
  assign nxt_irq_b_n   = sync_ff[LANE_PHY_IRQ] & sync_ff[LANE_RTC_IRQ];
  // any of the three supply faults counts; no latching, level follows the switch
  assign nxt_usb_fault = sync_ff[LANE_USB_ILIM] | sync_ff[LANE_USB_THERM]
                         | undervoltage_lockout_sync_ff;
  assign nxt_irq_c_n   = ~nxt_usb_fault;
  assign nxt_irq_d_n   = sync_ff[LANE_PCI_INTA];
  assign nxt_irq_e_n   = sync_ff[LANE_PCI_INTB];

  // registered so every line seen by the processor is glitch free
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_irq_line_b_n    <= IRQ_LEVEL_IDLE;
      ext_irq_line_c_n    <= IRQ_LEVEL_IDLE;
      ext_irq_line_d_n    <= IRQ_LEVEL_IDLE;
      ext_irq_line_e_n    <= IRQ_LEVEL_IDLE;
      usb_power_fault_irq <= 1'b0;
    end else begin
      ext_irq_line_b_n    <= nxt_irq_b_n;
      ext_irq_line_c_n    <= nxt_irq_c_n;
      ext_irq_line_d_n    <= nxt_irq_d_n;
      ext_irq_line_e_n    <= nxt_irq_e_n;
      usb_power_fault_irq <= nxt_usb_fault;
    end
  end

endmodule

`default_nettype wire

// ===== verification/board_reset_glue_asserts.sv
// concurrent checks on the board reset glue ports
`timescale 1ns/100ps
`default_nettype none

module board_reset_glue_asserts #(
  parameter int unsigned POR_HOLD_CYCLES = 20,
  parameter int unsigned DEBOUNCE_LEN    = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pwr_good_3v3,
  input wire logic push_button_n,
  input wire logic dbg_hard_reset_req_n,
  input wire logic dbg_soft_reset_req_n,
  input wire logic cpu_hard_reset_out_n,
  input wire logic phy_link_irq_n,
  input wire logic timekeeper_irq_n,
  input wire logic pci_inta_n,
  input wire logic pci_intb_n,
  input wire logic usb_current_limit,
  input wire logic usb_thermal_shutdown,
  input wire logic undervoltage_lockout,
  input wire logic power_on_reset_out_n,
  input wire logic hard_reset_n,
  input wire logic soft_reset_line_n,
  input wire logic board_reset_n,
  input wire logic manual_reset_input,
  input wire logic ext_irq_line_b_n,
  input wire logic ext_irq_line_c_n,
  input wire logic ext_irq_line_d_n,
  input wire logic ext_irq_line_e_n,
  input wire logic usb_power_fault_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // combined sources, so $past only ever sees a plain signal
  wire logic hard_src = dbg_hard_reset_req_n & cpu_hard_reset_out_n;
  wire logic irqb_src = phy_link_irq_n & timekeeper_irq_n;
  wire logic usb_src  = usb_current_limit | usb_thermal_shutdown | undervoltage_lockout;

  // run lengths; the first edges after reset still see flushed syncs
  int unsigned up_ff;
  int unsigned por_lo_ff;
  int unsigned btn_lo_ff;
  always_ff @(posedge clk_sys) begin
    up_ff     <= rst ? 0 : (up_ff < 4 ? up_ff + 1 : up_ff);
    por_lo_ff <= (rst || power_on_reset_out_n) ? 0 : por_lo_ff + 1;
    btn_lo_ff <= (rst || push_button_n) ? 0 : btn_lo_ff + 1;
  end
  wire logic settled = (up_ff == 4);

  sequence s_press;
    $rose(manual_reset_input);
  endsequence

  a_hard_follow: assert property (settled |->
    hard_reset_n == $past(hard_src, 3)) else $error("hard reset not following sources");
  a_soft_follow: assert property (settled |->
    soft_reset_line_n == $past(dbg_soft_reset_req_n, 3)) else $error("soft reset wrong");
  a_irq_b_or: assert property (settled |->
    ext_irq_line_b_n == $past(irqb_src, 3)) else $error("line b not phy or rtc");
  a_pci_route: assert property (settled |-> ext_irq_line_d_n == $past(pci_inta_n, 3)
    && ext_irq_line_e_n == $past(pci_intb_n, 3)) else $error("slot lines misrouted");
  a_usb_fault: assert property (settled |-> usb_power_fault_irq == $past(usb_src, 3)
    && ext_irq_line_c_n == !usb_power_fault_irq) else $error("usb fault wrong");
  a_common_rst: assert property (
    board_reset_n == (power_on_reset_out_n & hard_reset_n)) else $error("common reset wrong");
  a_por_hold: assert property ($rose(power_on_reset_out_n) |->
    por_lo_ff >= POR_HOLD_CYCLES && $past(pwr_good_3v3, 3)) else $error("por too short");
  a_press_por: assert property (s_press |-> !power_on_reset_out_n)
    else $error("press without por");
  a_debounce_len: assert property (s_press |-> btn_lo_ff >= DEBOUNCE_LEN)
    else $error("press accepted too early");
endmodule

bind board_reset_glue board_reset_glue_asserts #(
  .POR_HOLD_CYCLES(POR_HOLD_CYCLES),
  .DEBOUNCE_LEN(DEBOUNCE_LEN)
) chk_u (.*);

`default_nettype wire

// ===== verification/host_debug_model.sv
// processor and debug probe reset request pins
`timescale 1ns/100ps
`default_nettype none

module host_debug_model (
  input  wire logic clk_sys,
  input  wire logic want_hard,
  input  wire logic want_soft,
  input  wire logic want_cpu,
  output logic      dbg_hard_reset_req_n,
  output logic      dbg_soft_reset_req_n,
  output logic      cpu_hard_reset_out_n
);
  initial {dbg_hard_reset_req_n, dbg_soft_reset_req_n, cpu_hard_reset_out_n} = 3'h7;
  // requests are pulled low, changed just after the falling edge
  always @(negedge clk_sys) begin
    dbg_hard_reset_req_n <= !want_hard;
    dbg_soft_reset_req_n <= !want_soft;
    cpu_hard_reset_out_n <= !want_cpu;
  end
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the board reset and interrupt glue
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int unsigned HOLD = 20;
  localparam int unsigned DEB  = 4;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       pwr_good_3v3 = 1'b1;
  logic       push_button_n = 1'b1;
  logic [2:0] req = 3'h0;   // debug hard, debug soft, cpu hard
  logic [6:0] irq = 7'h78;  // phy rtc inta intb ilim therm undervoltage_lockout
  logic       dbg_hard_reset_req_n, dbg_soft_reset_req_n, cpu_hard_reset_out_n;
  logic       power_on_reset_out_n, hard_reset_n, soft_reset_line_n, board_reset_n;
  logic       manual_reset_input, usb_power_fault_irq;
  logic       ext_irq_line_b_n, ext_irq_line_c_n, ext_irq_line_d_n, ext_irq_line_e_n;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         seed = 32;
  int         n;

  always #2 clk_sys = ~clk_sys;

  host_debug_model host_u (.clk_sys, .want_hard(req[2]), .want_soft(req[1]),
    .want_cpu(req[0]), .dbg_hard_reset_req_n, .dbg_soft_reset_req_n, .cpu_hard_reset_out_n);

  board_reset_glue #(.POR_HOLD_CYCLES(HOLD), .DEBOUNCE_LEN(DEB)) dut_u (
    .clk_sys, .rst, .pwr_good_3v3, .push_button_n, .dbg_hard_reset_req_n,
    .dbg_soft_reset_req_n, .cpu_hard_reset_out_n, .phy_link_irq_n(irq[6]),
    .timekeeper_irq_n(irq[5]), .pci_inta_n(irq[4]), .pci_intb_n(irq[3]),
    .usb_current_limit(irq[2]), .usb_thermal_shutdown(irq[1]),
    .undervoltage_lockout(irq[0]), .power_on_reset_out_n, .hard_reset_n,
    .soft_reset_line_n, .board_reset_n, .manual_reset_input, .ext_irq_line_b_n,
    .ext_irq_line_c_n, .ext_irq_line_d_n, .ext_irq_line_e_n, .usb_power_fault_irq);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // bounded wait for power-on reset to lift, counted in cycles
  task automatic wait_por(output int cnt);
    cnt = 0;
    while (power_on_reset_out_n !== 1'b1) begin
      @(negedge clk_sys);
      cnt++;
      if (cnt > 1000) begin
        n_mismatch++;
        conclude();
      end
    end
  endtask

  // hard, soft, common, lines b c d e, usb fault; por assumed released
  function automatic logic [7:0] expect_out(input logic [2:0] r, input logic [6:0] q);
    logic h;
    h = !(r[2] | r[0]);
    return {h, !r[1], h, q[6] & q[5], !(|q[2:0]), q[4], q[3], |q[2:0]};
  endfunction

  initial begin
    repeat (8) @(negedge clk_sys);
    check("reset state", {power_on_reset_out_n, board_reset_n, hard_reset_n,
      soft_reset_line_n, manual_reset_input, usb_power_fault_irq}, 8'h0c);
    rst <= 1'b0;
    wait_por(n);
    check("por hold", 8'(n >= HOLD && n <= HOLD + 8), 8'h1);
    // all active, all idle, then random source mixes
    for (int i = 0; i < 300; i++) begin
      req <= (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($random(seed));
      irq <= (i == 0) ? 7'h07 : (i == 1) ? 7'h78 : 7'($random(seed));
      repeat (5) @(negedge clk_sys);
      check("routed outputs", {hard_reset_n, soft_reset_line_n, board_reset_n,
        ext_irq_line_b_n, ext_irq_line_c_n, ext_irq_line_d_n, ext_irq_line_e_n,
        usb_power_fault_irq}, expect_out(req, irq));
      check("por untouched", {power_on_reset_out_n, manual_reset_input}, 8'h2);
    end
    req <= 3'h0;
    irq <= 7'h78;
    // a bounce shorter than the filter must not reset the card
    push_button_n <= 1'b0;
    repeat (DEB - 1) @(negedge clk_sys);
    push_button_n <= 1'b1;
    repeat (DEB + 6) @(negedge clk_sys);
    check("short glitch", {power_on_reset_out_n, manual_reset_input}, 8'h2);
    push_button_n <= 1'b0;
    repeat (DEB + 6) @(negedge clk_sys);
    check("press", {power_on_reset_out_n, board_reset_n, manual_reset_input}, 8'h1);
    push_button_n <= 1'b1;
    wait_por(n);
    check("hold after press", 8'(n >= HOLD + DEB), 8'h1);
    pwr_good_3v3 <= 1'b0;
    repeat (HOLD * 2) @(negedge clk_sys);
    check("supply lost", {power_on_reset_out_n, board_reset_n}, 8'h0);
    pwr_good_3v3 <= 1'b1;
    wait_por(n);
    check("hold after supply", 8'(n >= HOLD), 8'h1);
    conclude();
  end
endmodule

`default_nettype wire
